// ### rtl/mclp_params.svh
`ifndef MCLP_PARAMS_SVH
`define MCLP_PARAMS_SVH

// timing, in ns as printed, and derived cycle counts
`define MCLP_SYS_PERIOD_NS     10
`define MCLP_BACKUP_PERIOD_NS  100
`define MCLP_SLOW_PERIOD_NS    31250
`define MCLP_BACKUP_CYCLES     (`MCLP_BACKUP_PERIOD_NS / `MCLP_SYS_PERIOD_NS)
`define MCLP_SLOW_CYCLES       (`MCLP_SLOW_PERIOD_NS / `MCLP_SYS_PERIOD_NS)

// missing-clock limit, in backup clock periods without a reference edge
`define MCLP_MISS_LIMIT        4'h4

// divider field width; code n divides by n+1
`define MCLP_DIV_W             6
`define MCLP_USB_POST_DIV      6'h03

// usb pll multiplier field
`define MCLP_USB_MULT_W        6
`define MCLP_USB_BYPASS_CODE   6'h00

// deep-sleep source select codes
`define MCLP_DS_SRC_SLOW       2'h0
`define MCLP_DS_SRC_BACKUP     2'h1
`define MCLP_DS_SRC_OSC        2'h2

// can clock select codes
`define MCLP_CAN_SRC_SUBSYS    2'h0
`define MCLP_CAN_SRC_OSC       2'h1
`define MCLP_CAN_SRC_EXT       2'h2

// reset values and peripheral count
`define MCLP_OWNER_RESET       1'b0
`define MCLP_PERIPH_COUNT      8

`endif

// ### rtl/mclp_pkg.sv
package mclp_pkg;
  typedef enum logic [1:0] {
    MS_RUN,
    MS_SLEEP,
    MS_DEEP,
    MS_HANDLER
  } mclp_mode_t;
endpackage

// ### rtl/mclp_clkdiv.sv
`include "mclp_params.svh"

// divides a source tick stream by code+1; output is a registered pulse
module mclp_clkdiv #(
  parameter int W = `MCLP_DIV_W
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // source and ratio
  input  wire logic         src_tick,
  input  wire logic [W-1:0] div,
  // divided tick
  output logic              out_tick
);
  logic [W-1:0] cnt;
  wire          wrap = (cnt >= div);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt      <= '0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= src_tick & wrap;
      if (src_tick) begin
        cnt <= wrap ? '0 : cnt + 1'b1;
      end
    end
  end
endmodule

// ### rtl/mclp_top.sv
`include "mclp_params.svh"

module mclp_top #(
  parameter int NP = `MCLP_PERIPH_COUNT,
  parameter int DW = `MCLP_DIV_W
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // pins from other clock domains
  input  wire logic                        osc_ref_pin,
  input  wire logic                        external_clock_input,
  // pll output ticks, same domain
  input  wire logic                        pll_out_tick,
  input  wire logic                        usb_pll_out_tick,
  // clock configuration
  input  wire logic                        main_pll_output_enable,
  input  wire logic [DW-1:0]               system_clock_divider,
  input  wire logic [DW-1:0]               master_subsystem_divider,
  input  wire logic [DW-1:0]               analog_clock_control,
  input  wire logic                        analog_src_osc,
  input  wire logic [1:0]                  deep_sleep_src,
  input  wire logic [DW-1:0]               deep_sleep_clock_config,
  input  wire logic [`MCLP_USB_MULT_W-1:0] pll_integer_multiplier_field,
  input  wire logic                        usb_ref_ext,
  input  wire logic [1:0]                  can_clk_sel,
  // gating
  input  wire logic [NP-1:0]               run_gating_register,
  input  wire logic [NP-1:0]               sleep_gating_register,
  input  wire logic [NP-1:0]               deep_sleep_gating_register,
  input  wire logic [NP-1:0]               periph_enable,
  input  wire logic                        auto_gating_select,
  // master core events and control bits
  input  wire logic                        wfi,
  input  wire logic                        irq_wake,
  input  wire logic                        handler_return,
  input  wire logic                        deep_low_power_select,
  input  wire logic                        sleep_on_handler_exit,
  // pll register ownership
  input  wire logic                        control_core_write_request,
  input  wire logic                        master_core_write_reclaim,
  input  wire logic                        master_pll_write,
  input  wire logic                        control_pll_write,
  // derived clock ticks
  output logic                             system_pll_clock,
  output logic                             master_subsystem_clock,
  output logic                             analog_subsystem_clock,
  output logic                             deep_sleep_divided_clock,
  output logic                             core_clk,
  output logic                             control_shared_clk,
  output logic [NP-1:0]                    periph_clk,
  output logic                             usb_clk,
  output logic                             can_clk,
  output logic                             wdog_clk,
  // status
  output logic                             main_pll_on,
  output logic                             usb_pll_on,
  output logic                             osc_on,
  output logic                             clock_failure_flag,
  output mclp_pkg::mclp_mode_t             lp_mode,
  output logic                             pll_owner_control,
  output logic                             pll_reg_write,
  output logic [`MCLP_USB_MULT_W-1:0]      usb_pll_ratio,
  output logic                             usb_pll_bypass
);
  import mclp_pkg::*;

  localparam int BK_CYC = `MCLP_BACKUP_CYCLES;
  localparam int SL_CYC = `MCLP_SLOW_CYCLES;

  function automatic logic [`MCLP_USB_MULT_W-1:0] usb_ratio(
    input logic [`MCLP_USB_MULT_W-1:0] code
  );
    return code;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // internal backup and slow clock ticks
  logic [3:0]  bk_cnt;
  logic [11:0] sl_cnt;
  logic        backup_tick;
  logic        slow_tick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bk_cnt      <= 4'h0;
      backup_tick <= 1'b0;
    end else begin
      backup_tick <= (bk_cnt == 4'(BK_CYC - 1));
      bk_cnt      <= (bk_cnt == 4'(BK_CYC - 1)) ? 4'h0 : bk_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sl_cnt    <= 12'h000;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (sl_cnt == 12'(SL_CYC - 1));
      sl_cnt    <= (sl_cnt == 12'(SL_CYC - 1)) ? 12'h000 : sl_cnt + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 oscillator, bit 1 external input
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  logic [1:0] pin_lvl_d;
  wire  [1:0] next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
  wire        osc_tick     = pin_lvl[0] & ~pin_lvl_d[0];
  wire        ext_tick     = pin_lvl[1] & ~pin_lvl_d[1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1    <= 2'h0;
      pin_s2    <= 2'h0;
      pin_s3    <= 2'h0;
      pin_lvl   <= 2'h0;
      pin_lvl_d <= 2'h0;
    end else begin
      pin_s1    <= {external_clock_input, osc_ref_pin};
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_lvl   <= next_pin_lvl;
      pin_lvl_d <= pin_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // missing-clock detector
  logic [3:0] miss_cnt;
  logic       fail_sel;
  wire        in_deep = (lp_mode == MS_DEEP);
  wire        in_sleep = (lp_mode == MS_SLEEP);
  wire        miss_hit = backup_tick & (miss_cnt == `MCLP_MISS_LIMIT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      miss_cnt           <= 4'h0;
      clock_failure_flag <= 1'b0;
    end else begin
      if (osc_tick || !osc_on) begin
        miss_cnt <= 4'h0;
      end else if (backup_tick && miss_cnt != `MCLP_MISS_LIMIT) begin
        miss_cnt <= miss_cnt + 4'h1;
      end
      if (miss_hit) begin
        clock_failure_flag <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock trees
  wire          sys_src_tick = main_pll_output_enable ? pll_out_tick
                                                      : osc_tick;
  wire          sysdiv_tick;
  wire          sys_tick;
  wire          ms_tick;
  wire          adiv_tick;
  wire          ds1_tick;
  wire          ds_tick;
  wire          usb_div_tick;
  logic         ds_src_tick;
  logic         can_src_tick;

  // swap only where neither stream has a pulse in flight
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fail_sel <= 1'b0;
    end else if (clock_failure_flag && !sysdiv_tick && !backup_tick) begin
      fail_sel <= 1'b1;
    end
  end

  mclp_clkdiv #(.W(DW)) u_sysdiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (sys_src_tick),
    .div      (system_clock_divider),
    .out_tick (sysdiv_tick)
  );

  assign sys_tick = fail_sel ? backup_tick : sysdiv_tick;

  mclp_clkdiv #(.W(DW)) u_msdiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (sys_tick),
    .div      (master_subsystem_divider),
    .out_tick (ms_tick)
  );

  mclp_clkdiv #(.W(DW)) u_adiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (analog_src_osc ? osc_tick : sys_tick),
    .div      (analog_clock_control),
    .out_tick (adiv_tick)
  );

  always_comb begin
    case (deep_sleep_src)
      `MCLP_DS_SRC_SLOW:   ds_src_tick = slow_tick;
      `MCLP_DS_SRC_BACKUP: ds_src_tick = backup_tick;
      default:             ds_src_tick = osc_tick;
    endcase
  end

  mclp_clkdiv #(.W(DW)) u_dsdiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (ds_src_tick),
    .div      (deep_sleep_clock_config),
    .out_tick (ds1_tick)
  );

  mclp_clkdiv #(.W(DW)) u_ds2div (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (ds1_tick),
    .div      (master_subsystem_divider),
    .out_tick (ds_tick)
  );

  mclp_clkdiv #(.W(DW)) u_usbdiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .src_tick (usb_pll_out_tick),
    .div      (`MCLP_USB_POST_DIV),
    .out_tick (usb_div_tick)
  );

  always_comb begin
    case (can_clk_sel)
      `MCLP_CAN_SRC_OSC: can_src_tick = osc_tick;
      `MCLP_CAN_SRC_EXT: can_src_tick = ext_tick;
      default:           can_src_tick = ms_tick;
    endcase
  end

  wire usb_byp   = (pll_integer_multiplier_field == `MCLP_USB_BYPASS_CODE);
  wire usb_ref   = usb_ref_ext ? ext_tick : osc_tick;
  wire usb_tick  = usb_byp ? usb_ref : usb_div_tick;
  wire ana_tick  = fail_sel ? backup_tick : adiv_tick;

  //////////////////////////////////////////////////////////////////////////
  // peripheral gating selection
  wire [NP-1:0] gate_sel =
    (auto_gating_select && in_sleep) ? sleep_gating_register :
    (auto_gating_select && in_deep)  ? deep_sleep_gating_register :
                                       run_gating_register;
  wire [NP-1:0] gate       = gate_sel & periph_enable;
  wire          periph_src = in_deep ? ds_tick : ms_tick;
  wire          core_act   = (lp_mode == MS_RUN) || (lp_mode == MS_HANDLER);
  wire          osc_keep   = !in_deep || (deep_sleep_src == `MCLP_DS_SRC_OSC);

  //////////////////////////////////////////////////////////////////////////
  // low-power mode sequencer
  mclp_mode_t next_lp_mode;
  logic       saved_deep;

  always_comb begin
    next_lp_mode = lp_mode;
    case (lp_mode)
      MS_RUN: begin
        if (wfi) begin
          next_lp_mode = deep_low_power_select ? MS_DEEP : MS_SLEEP;
        end
      end
      MS_SLEEP, MS_DEEP: begin
        if (irq_wake) begin
          next_lp_mode = sleep_on_handler_exit ? MS_HANDLER : MS_RUN;
        end
      end
      MS_HANDLER: begin
        if (handler_return) begin
          next_lp_mode = saved_deep ? MS_DEEP : MS_SLEEP;
        end
      end
      default: next_lp_mode = MS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lp_mode    <= MS_RUN;
      saved_deep <= 1'b0;
    end else begin
      lp_mode <= next_lp_mode;
      if (lp_mode != MS_HANDLER) begin
        saved_deep <= in_deep;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pll register ownership
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_owner_control <= `MCLP_OWNER_RESET;
      pll_reg_write     <= 1'b0;
    end else begin
      if (master_core_write_reclaim) begin
        pll_owner_control <= 1'b0;
      end else if (control_core_write_request) begin
        pll_owner_control <= 1'b1;
      end
      pll_reg_write <= pll_owner_control ? control_pll_write
                                         : master_pll_write;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      system_pll_clock         <= 1'b0;
      master_subsystem_clock   <= 1'b0;
      analog_subsystem_clock   <= 1'b0;
      deep_sleep_divided_clock <= 1'b0;
      core_clk                 <= 1'b0;
      control_shared_clk       <= 1'b0;
      periph_clk               <= '0;
      usb_clk                  <= 1'b0;
      can_clk                  <= 1'b0;
      wdog_clk                 <= 1'b0;
      main_pll_on              <= 1'b1;
      usb_pll_on               <= 1'b1;
      osc_on                   <= 1'b1;
      usb_pll_ratio            <= '0;
      usb_pll_bypass           <= 1'b1;
    end else begin
      system_pll_clock         <= sys_tick & ~in_deep;
      master_subsystem_clock   <= ms_tick;
      analog_subsystem_clock   <= ana_tick & ~in_deep;
      deep_sleep_divided_clock <= ds_tick;
      core_clk                 <= ms_tick & core_act;
      control_shared_clk       <= sys_tick & ~in_deep;
      periph_clk               <= {NP{periph_src}} & gate;
      usb_clk                  <= usb_tick & ~in_deep;
      can_clk                  <= can_src_tick & ~in_deep;
      wdog_clk                 <= osc_tick;
      main_pll_on              <= ~in_deep;
      usb_pll_on               <= ~in_deep;
      osc_on                   <= osc_keep;
      usb_pll_ratio            <= usb_ratio(pll_integer_multiplier_field);
      usb_pll_bypass           <= usb_byp;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_sleep_wfi;
    lp_mode == MS_RUN && wfi && !deep_low_power_select;
  endsequence

  a_usb_ratio: assert property (
    pll_integer_multiplier_field[5] |=>
      usb_pll_ratio == $past(pll_integer_multiplier_field) && !usb_pll_bypass)
    else $error("usb ratio differs from code");
  a_fail_subst: assert property (
    fail_sel && backup_tick && !in_deep |=> system_pll_clock)
    else $error("backup tick not substituted");
  a_fail_sticky: assert property (
    clock_failure_flag |=> clock_failure_flag)
    else $error("clock failure flag dropped");
  a_owner_move: assert property (
    control_core_write_request && !master_core_write_reclaim
      |=> pll_owner_control)
    else $error("control request not granted");
  a_sleep_enter: assert property (
    seq_sleep_wfi |=> lp_mode == MS_SLEEP ##1 !core_clk)
    else $error("sleep entry or core stop failed");
  a_deep_off: assert property (
    lp_mode == MS_DEEP |=> !main_pll_on && !usb_pll_on && !control_shared_clk)
    else $error("pll or shared clock on in deep sleep");
  a_wake_run: assert property (
    (lp_mode == MS_SLEEP || lp_mode == MS_DEEP) && irq_wake
      && !sleep_on_handler_exit |=> lp_mode == MS_RUN)
    else $error("wake did not return to run");
  a_handler_back: assert property (
    lp_mode == MS_HANDLER && handler_return |=>
      lp_mode == ($past(saved_deep) ? MS_DEEP : MS_SLEEP))
    else $error("handler exit did not resume low power");
  a_gate_enable: assert property (
    1'b1 |=> (periph_clk & ~$past(periph_enable)) == '0)
    else $error("disabled peripheral clocked");
  a_osc_off: assert property (
    in_deep && deep_sleep_src != `MCLP_DS_SRC_OSC |=> !osc_on)
    else $error("oscillator left on in deep sleep");
endmodule

// ### verif/mclp_far_model.sv
// stands in for the crystal, the external clock pin and the two plls
module mclp_far_model (
  // clock
  input  wire logic sys_clk,
  // device controls seen by the far side
  input  wire logic osc_on,
  input  wire logic osc_stop,
  input  wire logic main_pll_on,
  input  wire logic usb_pll_on,
  // far-side clocks
  output logic      osc_ref_pin,
  output logic      external_clock_input,
  output logic      pll_out_tick,
  output logic      usb_pll_out_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ph;

  ////////////////////////////////////////////////////////////////////////////
  // crystal, 80 ns period, halts low when switched off or lost
  initial begin
    osc_ref_pin = 1'h0;
    #3;
    forever begin
      #40;
      osc_ref_pin = (osc_on === 1'h1 && !osc_stop) ? !osc_ref_pin : 1'h0;
    end
  end

  // external pin, 120 ns period, unrelated phase
  initial begin
    external_clock_input = 1'h0;
    #7;
    forever #60 external_clock_input = !external_clock_input;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll ticks every second cycle, none while the pll is off
  initial begin
    ph = 1'h0;
    pll_out_tick = 1'h0;
    usb_pll_out_tick = 1'h0;
    forever begin
      @(negedge sys_clk);
      ph <= !ph;
      pll_out_tick <= ph && main_pll_on === 1'h1;
      usb_pll_out_tick <= ph && usb_pll_on === 1'h1;
    end
  end
endmodule

// ### verif/master_clock_lowpower_control_test.sv
module master_clock_lowpower_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mclp_pkg::*;

  localparam int W = 400;
  localparam int SYS = 0, SUB = 1, ANA = 2, DSL = 3, CORE = 4;
  localparam int SHR = 5, USB = 6, CAN = 7, WDG = 8;

  ////////////////////////////////////////////////////////////////////////////
  logic       sys_clk = 1'h0, rst = 1'h1, osc_stop = 1'h0, clr = 1'h1;
  logic       main_pll_output_enable = 1'h1, analog_src_osc = 1'h0;
  logic [5:0] system_clock_divider = 6'h01, master_subsystem_divider = 6'h00;
  logic [5:0] analog_clock_control = 6'h01, deep_sleep_clock_config = 6'h01;
  logic [5:0] pll_integer_multiplier_field = 6'h20;
  logic [1:0] deep_sleep_src = 2'h1, can_clk_sel = 2'h0;
  logic       usb_ref_ext = 1'h1, auto_gating_select = 1'h0;
  logic       deep_low_power_select = 1'h0, sleep_on_handler_exit = 1'h0;
  logic [7:0] run_gating_register = 8'h0F, sleep_gating_register = 8'hF0;
  logic [7:0] deep_sleep_gating_register = 8'h5A, periph_enable = 8'h33;
  logic [6:0] evt = 7'h00;
  logic       osc_ref_pin, external_clock_input, pll_out_tick;
  logic       usb_pll_out_tick, system_pll_clock, master_subsystem_clock;
  logic       analog_subsystem_clock, deep_sleep_divided_clock, core_clk;
  logic       control_shared_clk, usb_clk, can_clk, wdog_clk, main_pll_on;
  logic       usb_pll_on, osc_on, clock_failure_flag, pll_owner_control;
  logic       pll_reg_write, usb_pll_bypass;
  logic [7:0] periph_clk, seen;
  logic [5:0] usb_pll_ratio;
  logic [8:0] tk;
  mclp_mode_t lp_mode;
  int         cnt [9];
  int         bad_count = 0, tests_run = 0;

  always #5 sys_clk = !sys_clk;

  mclp_top mclp_top_i (
    .sys_clk, .rst, .osc_ref_pin, .external_clock_input, .pll_out_tick,
    .usb_pll_out_tick, .main_pll_output_enable, .system_clock_divider,
    .master_subsystem_divider, .analog_clock_control, .analog_src_osc,
    .deep_sleep_src, .deep_sleep_clock_config, .pll_integer_multiplier_field,
    .usb_ref_ext, .can_clk_sel, .run_gating_register, .sleep_gating_register,
    .deep_sleep_gating_register, .periph_enable, .auto_gating_select,
    .wfi(evt[0]), .irq_wake(evt[1]), .handler_return(evt[2]),
    .deep_low_power_select, .sleep_on_handler_exit,
    .control_core_write_request(evt[3]), .master_core_write_reclaim(evt[4]),
    .master_pll_write(evt[5]), .control_pll_write(evt[6]),
    .system_pll_clock, .master_subsystem_clock, .analog_subsystem_clock,
    .deep_sleep_divided_clock, .core_clk, .control_shared_clk, .periph_clk,
    .usb_clk, .can_clk, .wdog_clk, .main_pll_on, .usb_pll_on, .osc_on,
    .clock_failure_flag, .lp_mode, .pll_owner_control, .pll_reg_write,
    .usb_pll_ratio, .usb_pll_bypass
  );

  mclp_far_model mclp_far_model_i (
    .sys_clk, .osc_on, .osc_stop, .main_pll_on, .usb_pll_on, .osc_ref_pin,
    .external_clock_input, .pll_out_tick, .usb_pll_out_tick
  );

  ////////////////////////////////////////////////////////////////////////////
  // tick counters over a measuring window
  assign tk = {wdog_clk, can_clk, usb_clk, control_shared_clk, core_clk,
               deep_sleep_divided_clock, analog_subsystem_clock,
               master_subsystem_clock, system_pll_clock};

  always @(posedge sys_clk) begin
    for (int i = 0; i < 9; i++) begin
      cnt[i] <= clr ? 0 : cnt[i] + (tk[i] === 1'h1 ? 1 : 0);
    end
    seen <= clr ? 8'h00 : seen | periph_clk;
  end

  task automatic window(input int n);
    @(negedge sys_clk);
    clr = 1'h1;
    @(negedge sys_clk);
    clr = 1'h0;
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic pulse(input int b);
    @(negedge sys_clk);
    evt[b] = 1'h1;
    @(negedge sys_clk);
    evt[b] = 1'h0;
  endtask

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // tick counts may be off by one at the window edges
  task automatic chk_near(input int got, input int exp);
    tests_run++;
    if (got < exp - 1 || got > exp + 1) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge sys_clk);
    chk_bits({6'h00, lp_mode}, {6'h00, MS_RUN});
    chk_bits({main_pll_on, usb_pll_on, pll_owner_control}, 8'h06);
    rst = 1'h0;
    // pll register ownership
    pulse(6);
    chk_bits(pll_reg_write, 8'h00);
    pulse(5);
    chk_bits(pll_reg_write, 8'h01);
    pulse(3);
    chk_bits(pll_owner_control, 8'h01);
    pulse(6);
    chk_bits(pll_reg_write, 8'h01);
    pulse(5);
    chk_bits(pll_reg_write, 8'h00);
    pulse(4);
    chk_bits(pll_owner_control, 8'h00);
    // usb multiplier codes
    for (int c = 32; c < 64; c++) begin
      pll_integer_multiplier_field = 6'(c);
      repeat (2) @(negedge sys_clk);
      chk_bits({usb_pll_bypass, usb_pll_ratio}, 8'(c));
    end
    // run mode frequencies
    window(W);
    chk_near(cnt[SYS], W / 4);
    chk_near(cnt[SUB], W / 4);
    chk_near(cnt[ANA], W / 8);
    chk_near(cnt[WDG], W / 8);
    chk_near(cnt[USB], W / 8);
    chk_bits(cnt[CORE] > 0 && cnt[SHR] > 0, 8'h01);
    chk_bits(seen, 8'h03);
    master_subsystem_divider = 6'h01;
    analog_src_osc = 1'h1;
    window(W);
    chk_near(cnt[SUB], W / 8);
    chk_near(cnt[ANA], W / 16);
    master_subsystem_divider = 6'h00;
    analog_src_osc = 1'h0;
    pll_integer_multiplier_field = 6'h00;
    main_pll_output_enable = 1'h0;
    window(W);
    chk_bits(usb_pll_bypass, 8'h01);
    chk_near(cnt[USB], W / 12);
    chk_near(cnt[SYS], W / 16);
    main_pll_output_enable = 1'h1;
    for (int s = 0; s < 4; s++) begin
      can_clk_sel = 2'(s);
      usb_ref_ext = (s == 2);
      window(W);
      chk_near(cnt[CAN], s == 1 ? W / 8 : (s == 2 ? W / 12 : W / 4));
      chk_near(cnt[USB], s == 2 ? W / 12 : W / 8);
    end
    // sleep with both gating choices, temporary and permanent wake
    for (int a = 0; a < 2; a++) begin
      auto_gating_select = 1'(a);
      pulse(0);
      chk_bits({6'h00, lp_mode}, {6'h00, MS_SLEEP});
      window(W);
      chk_bits(seen, a == 1 ? 8'h30 : 8'h03);
      chk_near(cnt[SUB], W / 4);
      chk_bits({cnt[CORE] == 0, cnt[SHR] > 0, main_pll_on}, 8'h07);
      sleep_on_handler_exit = 1'h1;
      pulse(1);
      chk_bits({6'h00, lp_mode}, {6'h00, MS_HANDLER});
      window(W / 4);
      chk_bits(cnt[CORE] > 0, 8'h01);
      pulse(2);
      chk_bits({6'h00, lp_mode}, {6'h00, MS_SLEEP});
      sleep_on_handler_exit = 1'h0;
      pulse(1);
      chk_bits({6'h00, lp_mode}, {6'h00, MS_RUN});
    end
    // deep sleep from the backup clock, then from the oscillator
    deep_low_power_select = 1'h1;
    pulse(0);
    chk_bits({6'h00, lp_mode}, {6'h00, MS_DEEP});
    window(W);
    chk_bits({main_pll_on, usb_pll_on}, 8'h00);
    chk_bits(osc_on, 8'h00);
    chk_bits({7'h00, cnt[SYS] + cnt[ANA] + cnt[SHR] > 0}, 8'h00);
    chk_bits({7'h00, cnt[USB] + cnt[CAN] > 0}, 8'h00);
    chk_near(cnt[DSL], W / 20);
    chk_bits(seen, 8'h12);
    pulse(1);
    chk_bits({6'h00, lp_mode}, {6'h00, MS_RUN});
    deep_sleep_src = 2'h2;
    pulse(0);
    window(W);
    chk_bits(osc_on, 8'h01);
    chk_near(cnt[DSL], W / 16);
    pulse(1);
    // slow source, one tick per 3125 cycles
    deep_sleep_src = 2'h0;
    deep_sleep_clock_config = 6'h00;
    pulse(0);
    window(6250);
    chk_bits(osc_on, 8'h00);
    chk_near(cnt[DSL], 2);
    pulse(1);
    deep_low_power_select = 1'h0;
    window(8);
    chk_bits({main_pll_on, usb_pll_on}, 8'h03);
    // lost oscillator reference
    osc_stop = 1'h1;
    repeat (120) @(negedge sys_clk);
    chk_bits(clock_failure_flag, 8'h01);
    window(W);
    chk_near(cnt[SUB], W / 10);
    chk_near(cnt[ANA], W / 10);
    osc_stop = 1'h0;
    repeat (40) @(negedge sys_clk);
    chk_bits(clock_failure_flag, 8'h01);
    rst = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk_bits({clock_failure_flag, pll_owner_control}, 8'h00);
    chk_bits({6'h00, lp_mode}, {6'h00, MS_RUN});
    rst = 1'h0;
    tally_and_finish();
  end
endmodule
